// ### src/rxm_ext_mem_port.sv
// Purpose : External memory port, shared pins for serial memories or DRAM
// Assumes : One access per request; link_clk_in paces the memory pins
// Notes   : Mode pins are sampled at the start of each access
//
// Overview of operation
// - Type select low means serial memory, high means DRAM; pins follow it.
// - Width select low gives one-bit DRAM access, high gives four-bit access.
// - A0/A1 carry DRAM address bits, or serial leading address lines.
// - A2 carries DRAM bit 2, or the serial address-load strobe.
// - A3 carries DRAM bit 3, or the serial address clock.
// - A4 carries DRAM bit 4, or the serial data clock.
// - A5 to A10 carry upper DRAM address bits in DRAM mode.
// - Write enable puts the memory in read or write mode per access.
// - Data line driven with write data on writes except to the voice ROM, sampled on reads.
// - Voice ROM data arrives on its own input, apart from the data line.
// - DRAM mode drives a row strobe and one column strobe per device.
// - Four active-low chip selects pick among the serial devices.
// - Count and capacity selects set decode of address range and selects.
`default_nettype none

module rxm_ext_mem_port (
   input  wire logic                      mclk_in,
   input  wire logic                      rst_b_in,
   input  wire logic                      link_clk_in,
   input  wire logic                      req_valid_in,
   input  wire logic                      req_write_in,
   input  wire logic                      req_rom_in,
   input  wire logic [rxm_pkg::ADDR_W-1:0] req_addr_in,
   input  wire logic [rxm_pkg::DQ_W-1:0]  req_wdata_in,
   output logic                           req_ready_out,
   output logic                           rsp_valid_out,
   output logic [rxm_pkg::DQ_W-1:0]       rsp_rdata_out,
   output logic                           rsp_err_out,
   input  wire logic                      memory_type_select_in,
   input  wire logic                      dram_width_select_in,
   input  wire logic                      memory_count_sel_lo_in,
   input  wire logic                      memory_count_sel_hi_in,
   input  wire logic                      memory_capacity_sel_lo_in,
   input  wire logic                      memory_capacity_sel_hi_in,
   output logic [rxm_pkg::PIN_A_W-1:0]    mem_addr_out,
   output logic                           write_enable_b_out,
   output logic [rxm_pkg::DQ_W-1:0]       memory_data_line_out,
   output logic [rxm_pkg::DQ_W-1:0]       memory_data_line_oe_out,
   input  wire logic [rxm_pkg::DQ_W-1:0]  memory_data_line_in,
   input  wire logic                      voice_rom_data_in,
   output logic                           row_strobe_b_out,
   output logic [rxm_pkg::CAS_W-1:0]      col_strobe_b_out,
   output logic [rxm_pkg::CS_W-1:0]       memory_chip_selects_b_out
);
   // ==========================================================
   // State of both domains
   typedef struct packed {
      logic                       ready;
      logic                       rsp_valid;
      logic [rxm_pkg::DQ_W-1:0]   rsp_rdata;
      logic                       rsp_err;
      logic                       req_tgl;
      logic                       ack_seen;
      logic [rxm_pkg::ADDR_W-1:0] h_addr;
      logic                       h_wr;
      logic                       h_rom;
      logic [rxm_pkg::DQ_W-1:0]   h_wdata;
   } rxm_front_type;

   typedef struct packed {
      rxm_pkg::rxm_link_state_type state;
      logic                        phase;
      logic [4:0]                  cnt;
      logic [rxm_pkg::ADDR_W-1:0]  shift;
      logic                        wr;
      logic                        rom;
      logic [rxm_pkg::DQ_W-1:0]    wdata;
      logic                        is_dram;
      logic                        wide;
      logic [2:0]                  bank;
      logic                        err;
      logic [rxm_pkg::DQ_W-1:0]    rdata;
      logic                        ack_tgl;
      logic                        req_seen;
      logic [rxm_pkg::PIN_A_W-1:0] pins;
      logic                        we_b;
      logic [rxm_pkg::DQ_W-1:0]    dq_out;
      logic [rxm_pkg::DQ_W-1:0]    dq_oe;
      logic                        ras_b;
      logic [rxm_pkg::CAS_W-1:0]   cas_b;
      logic [rxm_pkg::CS_W-1:0]    cs_b;
   } rxm_link_type;

   rxm_front_type f;
   rxm_front_type next_f;
   rxm_link_type  l;
   rxm_link_type  next_l;

   logic [rxm_pkg::CFG_W-1:0] cfg_q;
   logic [rxm_pkg::PIN_W-1:0] pin_q;
   logic                      ack_q;
   logic [1:0]                ser_idx;
   logic                      ser_err;
   logic                      dram_err;

   // ==========================================================
   // Crossings: pins and request toggle into the link, ack back
   rxm_sync_if #(.W(rxm_pkg::CFG_W)) cfg_if (.clk(link_clk_in), .rst_b(rst_b_in));
   rxm_sync_if #(.W(rxm_pkg::PIN_W)) pin_if (.clk(link_clk_in), .rst_b(rst_b_in));
   rxm_sync_if #(.W(1))              ack_if (.clk(mclk_in), .rst_b(rst_b_in));

   assign cfg_if.d = {f.req_tgl, memory_capacity_sel_hi_in, memory_capacity_sel_lo_in,
                      memory_count_sel_hi_in, memory_count_sel_lo_in,
                      dram_width_select_in, memory_type_select_in};
   assign pin_if.d = {voice_rom_data_in, memory_data_line_in};  // ROM on its own input
   assign ack_if.d = l.ack_tgl;
   assign cfg_q    = cfg_if.q;
   assign pin_q    = pin_if.q;
   assign ack_q    = ack_if.q;

   rxm_sync #(.W(rxm_pkg::CFG_W)) u_cfg_sync (.port(cfg_if));
   rxm_sync #(.W(rxm_pkg::PIN_W)) u_pin_sync (.port(pin_if));
   rxm_sync #(.W(1))              u_ack_sync (.port(ack_if));

   // ==========================================================
   // Request side: holds the request stable until the link answers
   always_comb begin
      next_f           = f;
      next_f.rsp_valid = 1'b0;
      if (f.ready && req_valid_in) begin
         next_f.h_addr  = req_addr_in;
         next_f.h_wr    = req_write_in;
         next_f.h_rom   = req_rom_in;
         next_f.h_wdata = req_wdata_in;
         next_f.req_tgl = ~f.req_tgl;
         next_f.ready   = 1'b0;
      end
      // Link results are stable once its toggle is seen here
      if (ack_q != f.ack_seen) begin
         next_f.ack_seen  = ack_q;
         next_f.rsp_valid = 1'b1;
         next_f.rsp_rdata = l.rdata;
         next_f.rsp_err   = l.err;
         next_f.ready     = 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         f       <= '0;
         f.ready <= 1'b1;
      end else begin
         f <= next_f;
      end
   end

   // ==========================================================
   // Address decode from the count and capacity selects
   always_comb begin
      ser_idx  = cfg_q[2] ? f.h_addr[rxm_pkg::SER_IDX_LSB_LARGE +: 2]
                          : f.h_addr[rxm_pkg::SER_IDX_LSB_SMALL +: 2];
      ser_err  = f.h_rom ? ({2'h0, f.h_addr[rxm_pkg::SER_IDX_LSB_SMALL +: 2]} == rxm_pkg::ROM_NO_CHIP)
                         : (ser_idx > cfg_q[5:4]);
      dram_err = f.h_rom ||
                 ((f.h_addr[rxm_pkg::BANK_LSB +: 3] >> cfg_q[3:2]) != 3'h0);
   end

   // ==========================================================
   // Link sequencer: one state change per link clock
   always_comb begin
      next_l = l;
      case (l.state)
         rxm_pkg::LS_IDLE: begin
            if (cfg_q[6] != l.req_seen) begin
               next_l.req_seen = cfg_q[6];
               next_l.shift    = f.h_addr;
               next_l.wr       = f.h_wr;
               next_l.rom      = f.h_rom;
               next_l.wdata    = f.h_wdata;
               next_l.is_dram  = cfg_q[0];  // Mode taken per access
               next_l.wide     = cfg_q[1];
               next_l.bank     = f.h_addr[rxm_pkg::BANK_LSB +: 3];
               next_l.cnt      = 5'h00;
               next_l.phase    = 1'b0;
               next_l.rdata    = '0;
               if (cfg_q[0] ? dram_err : ser_err) begin
                  next_l.err   = 1'b1;
                  next_l.state = rxm_pkg::LS_FINISH;
               end else if (cfg_q[0]) begin
                  next_l.err   = 1'b0;
                  next_l.pins  = f.h_addr[rxm_pkg::ROW_LSB +: rxm_pkg::PIN_A_W];  // Row on A0..A10
                  next_l.state = rxm_pkg::LS_ROW;
               end else begin
                  next_l.err   = 1'b0;
                  next_l.pins  = '0;
                  next_l.pins[rxm_pkg::PIN_SER_Y] = f.h_addr[0];  // Leading address bits
                  next_l.pins[rxm_pkg::PIN_SER_X] = f.h_addr[1];
                  next_l.cs_b  = ~(4'h1 << (f.h_rom ? f.h_addr[rxm_pkg::SER_IDX_LSB_SMALL +: 2]
                                                    : ser_idx));
                  next_l.state = rxm_pkg::LS_SER_SHIFT;
               end
            end
         end
         rxm_pkg::LS_SER_SHIFT: begin
            if (!l.phase) begin
               next_l.pins[rxm_pkg::PIN_SER_ACLK] = 1'b1;  // Address clock rises on held bits
               next_l.phase = 1'b1;
            end else begin
               next_l.pins[rxm_pkg::PIN_SER_ACLK] = 1'b0;
               next_l.phase = 1'b0;
               next_l.shift = l.shift >> 2;
               next_l.cnt   = l.cnt + 5'h01;
               if (l.cnt == rxm_pkg::SER_PAIRS - 5'h01) begin
                  next_l.pins[rxm_pkg::PIN_SER_LOAD] = 1'b1;  // Load only after full shift
                  next_l.we_b  = ~l.wr;
                  next_l.state = rxm_pkg::LS_SER_LOAD;
               end else begin
                  next_l.pins[rxm_pkg::PIN_SER_Y] = l.shift[2];
                  next_l.pins[rxm_pkg::PIN_SER_X] = l.shift[3];
               end
            end
         end
         rxm_pkg::LS_SER_LOAD: begin
            next_l.pins[rxm_pkg::PIN_SER_LOAD] = 1'b0;
            next_l.dq_out = {3'h0, l.wdata[0]};
            next_l.dq_oe  = {3'h0, l.wr && !l.rom};  // Drive only on register writes
            next_l.state  = rxm_pkg::LS_SER_DATA;
         end
         rxm_pkg::LS_SER_DATA: begin
            next_l.pins[rxm_pkg::PIN_SER_DCLK] = 1'b1;  // Data clock after load
            next_l.cnt   = 5'h00;  // Shift count left here would stretch the settle by a wrap
            next_l.state = rxm_pkg::LS_SETTLE;
         end
         rxm_pkg::LS_ROW: begin
            next_l.ras_b = 1'b0;
            next_l.state = rxm_pkg::LS_RAS;
         end
         rxm_pkg::LS_RAS: begin
            next_l.pins   = l.shift[rxm_pkg::PIN_A_W-1:0];  // Column on A0..A10
            next_l.we_b   = ~l.wr;
            next_l.dq_out = l.wdata;
            next_l.dq_oe  = l.wr ? (l.wide ? 4'hf : 4'h1) : 4'h0;
            next_l.state  = rxm_pkg::LS_COL;
         end
         rxm_pkg::LS_COL: begin
            next_l.cas_b = ~(8'h01 << l.bank);  // One strobe per device
            next_l.state = rxm_pkg::LS_CAS;
         end
         rxm_pkg::LS_CAS: begin
            next_l.cnt   = 5'h00;
            next_l.state = rxm_pkg::LS_SETTLE;
         end
         rxm_pkg::LS_SETTLE: begin
            // Read data passes the pin synchroniser, so wait it out
            next_l.cnt = l.cnt + 5'h01;
            if (l.cnt == rxm_pkg::SAMPLE_WAIT) begin
               if (l.is_dram && l.wide) begin
                  next_l.rdata = pin_q[rxm_pkg::DQ_W-1:0];
               end else begin
                  next_l.rdata = {3'h0, l.rom ? pin_q[rxm_pkg::DQ_W] : pin_q[0]};
               end
               // Back to inactive levels so no stray edge reaches either type
               next_l.pins  = '0;
               next_l.we_b  = 1'b1;
               next_l.dq_oe = 4'h0;
               next_l.ras_b = 1'b1;
               next_l.cas_b = rxm_pkg::CAS_IDLE;
               next_l.cs_b  = rxm_pkg::CS_IDLE;
               next_l.state = rxm_pkg::LS_FINISH;
            end
         end
         rxm_pkg::LS_FINISH: begin
            next_l.ack_tgl = ~l.ack_tgl;
            next_l.state   = rxm_pkg::LS_IDLE;
         end
         default: begin
            next_l.state = rxm_pkg::LS_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         l       <= '0;
         l.state <= rxm_pkg::LS_IDLE;
         l.we_b  <= 1'b1;
         l.ras_b <= 1'b1;
         l.cas_b <= rxm_pkg::CAS_IDLE;
         l.cs_b  <= rxm_pkg::CS_IDLE;
      end else begin
         l <= next_l;
      end
   end

   // ==========================================================
   // Outputs, all straight from flops
   assign req_ready_out             = f.ready;
   assign rsp_valid_out             = f.rsp_valid;
   assign rsp_rdata_out             = f.rsp_rdata;
   assign rsp_err_out               = f.rsp_err;
   assign mem_addr_out              = l.pins;
   assign write_enable_b_out        = l.we_b;
   assign memory_data_line_out      = l.dq_out;
   assign memory_data_line_oe_out   = l.dq_oe;
   assign row_strobe_b_out          = l.ras_b;
   assign col_strobe_b_out          = l.cas_b;
   assign memory_chip_selects_b_out = l.cs_b;

   // ==========================================================
   // Checks
   property p_ser_no_dram_strobes;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      (l.state inside {rxm_pkg::LS_SER_SHIFT, rxm_pkg::LS_SER_LOAD, rxm_pkg::LS_SER_DATA})
         |-> (l.ras_b && (l.cas_b == rxm_pkg::CAS_IDLE));
   endproperty
   a_ser_no_dram_strobes: assert property (p_ser_no_dram_strobes) else $error("DRAM strobe in serial access");

   property p_dram_no_selects;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      l.is_dram && (l.state != rxm_pkg::LS_IDLE) |-> (l.cs_b == rxm_pkg::CS_IDLE);
   endproperty
   a_dram_no_selects: assert property (p_dram_no_selects) else $error("chip select in DRAM access");

   property p_dram_lane_width;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      (l.state == rxm_pkg::LS_COL) && l.wr |-> (l.dq_oe == (l.wide ? 4'hf : 4'h1));
   endproperty
   a_dram_lane_width: assert property (p_dram_lane_width) else $error("wrong DRAM lane drive");

   property p_load_after_shift;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      (l.state == rxm_pkg::LS_SER_LOAD) |-> ($past(l.state, 2) == rxm_pkg::LS_SER_SHIFT)
         && l.pins[rxm_pkg::PIN_SER_LOAD] ##1 !l.pins[rxm_pkg::PIN_SER_LOAD] ##1 l.pins[rxm_pkg::PIN_SER_DCLK];
   endproperty
   a_load_after_shift: assert property (p_load_after_shift) else $error("load strobe out of order");

   property p_addr_clock_in_shift;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      $rose(l.pins[rxm_pkg::PIN_SER_ACLK]) && !l.is_dram |-> (l.state == rxm_pkg::LS_SER_SHIFT) && l.phase;
   endproperty
   a_addr_clock_in_shift: assert property (p_addr_clock_in_shift) else $error("stray address clock");

   property p_data_clock_after_load;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      $rose(l.pins[rxm_pkg::PIN_SER_DCLK]) && !l.is_dram |-> $past(l.state, 2) == rxm_pkg::LS_SER_LOAD;
   endproperty
   a_data_clock_after_load: assert property (p_data_clock_after_load) else $error("data clock early");

   property p_drive_only_on_write;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      (l.dq_oe != 4'h0) |-> !l.we_b && l.wr;
   endproperty
   a_drive_only_on_write: assert property (p_drive_only_on_write) else $error("data driven on read");

   property p_cas_under_ras;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      (l.cas_b != rxm_pkg::CAS_IDLE) |-> !l.ras_b && $past(!l.ras_b, 2);
   endproperty
   a_cas_under_ras: assert property (p_cas_under_ras) else $error("column strobe without row strobe");

   property p_settle_bounded;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      (l.state == rxm_pkg::LS_SETTLE) |-> (l.cnt <= rxm_pkg::SAMPLE_WAIT);
   endproperty
   a_settle_bounded: assert property (p_settle_bounded) else $error("settle count out of range");

   property p_one_select;
      @(posedge link_clk_in) disable iff (!rst_b_in)
      (l.state == rxm_pkg::LS_SER_DATA) |-> $onehot(~l.cs_b) && !l.we_b == l.wr;
   endproperty
   a_one_select: assert property (p_one_select) else $error("bad select or write enable");

   property p_answer_frees;
      @(posedge mclk_in) disable iff (!rst_b_in)
      f.rsp_valid |-> f.ready ##1 !f.rsp_valid;
   endproperty
   a_answer_frees: assert property (p_answer_frees) else $error("answer did not free the port");
endmodule : rxm_ext_mem_port

`default_nettype wire

// ### src/rxm_pkg.sv
// Purpose : Shared constants and types for the recorder external memory port
// Assumes : Port logic on mclk_in, memory-facing logic on link_clk_in
// Notes   : Pin index constants name the dual role of the low address pins
`default_nettype none

package rxm_pkg;
   // ==========================================================
   // Widths
   localparam int ADDR_W  = 25;    // Request address width
   localparam int PIN_A_W = 11;    // Address pins A0..A10
   localparam int DQ_W    = 4;     // Data lanes, lane 0 is the shared data line
   localparam int CS_W    = 4;     // Serial chip selects
   localparam int CAS_W   = 8;     // Column strobes
   localparam int CFG_W   = 7;     // Synchronised configuration plus request toggle
   localparam int PIN_W   = 5;     // Synchronised data lanes plus voice ROM input

   // ==========================================================
   // Address pin roles in serial mode
   localparam int PIN_SER_Y    = 0;  // serial_addr_line_y
   localparam int PIN_SER_X    = 1;  // serial_addr_line_x
   localparam int PIN_SER_LOAD = 2;  // serial_addr_load_strobe
   localparam int PIN_SER_ACLK = 3;  // serial_addr_clock
   localparam int PIN_SER_DCLK = 4;  // serial_data_clock

   // ==========================================================
   // Request address fields
   localparam int ROW_LSB  = 11;   // Row half of a DRAM address
   localparam int BANK_LSB = 22;   // Column strobe index
   localparam int SER_IDX_LSB_SMALL = 22;  // Chip index for 4M devices
   localparam int SER_IDX_LSB_LARGE = 23;  // Chip index for 8M devices

   // ==========================================================
   // Sequencing counts
   localparam logic [4:0] SER_PAIRS   = 5'h0c;  // Address bit pairs per serial access
   localparam logic [4:0] SAMPLE_WAIT = 5'h03;  // Cycles before read data is taken
   localparam logic [3:0] ROM_NO_CHIP = 4'h3;   // Voice ROM has three selects only

   // ==========================================================
   // Reset values of pins
   localparam logic [CS_W-1:0]  CS_IDLE  = 4'hf;
   localparam logic [CAS_W-1:0] CAS_IDLE = 8'hff;

   typedef enum logic [3:0] {
      LS_IDLE,
      LS_SER_SHIFT,
      LS_SER_LOAD,
      LS_SER_DATA,
      LS_ROW,
      LS_RAS,
      LS_COL,
      LS_CAS,
      LS_SETTLE,
      LS_FINISH
   } rxm_link_state_type;
endpackage : rxm_pkg

`default_nettype wire

// ### src/rxm_sync.sv
// Purpose : Two flip-flop level synchroniser
// Assumes : Each bit is a level or a toggle, not a multi-bit word
// Notes   : The first stage feeds the second stage only
`default_nettype none

module rxm_sync #(
   parameter int W = 1
) (
   rxm_sync_if.sync_side port
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } rxm_sync_state_type;

   rxm_sync_state_type s;
   rxm_sync_state_type next_s;

   // ==========================================================
   // Stages
   always_comb begin
      next_s        = s;
      next_s.first  = port.d;
      next_s.second = s.first;
   end

   always_ff @(posedge port.clk or negedge port.rst_b) begin
      if (!port.rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign port.q = s.second;
endmodule : rxm_sync

`default_nettype wire

// ### src/rxm_sync_if.sv
// Purpose : Carries one synchroniser's clock, reset, input and output
// Assumes : d comes from outside the clk domain
// Notes   : q is the only side any logic may read
`default_nettype none

interface rxm_sync_if #(parameter int W = 1) (
   input wire logic clk,
   input wire logic rst_b
);
   logic [W-1:0] d;
   logic [W-1:0] q;
   modport sync_side (input clk, input rst_b, input d, output q);
   modport user      (output d, input q);
endinterface : rxm_sync_if

`default_nettype wire

// ### verification/rxm_ext_mem_port_bench.sv
// Purpose : Self-checking bench for the external memory port
// Assumes : Model holds one word; mode pins change only while idle
// Notes   : Reset spans four link clocks so both domains see it
`default_nettype none

module rxm_ext_mem_port_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0, lclk = 1'h0, rst_b = 1'h0, vld = 1'h0, wr = 1'h0, rom = 1'h0;
   logic ready, rsp, err, we_b, ras_b, rom_d;
   logic [24:0] addr = 25'h0000000;
   logic [3:0]  wd = 4'h0, rd, dout, oe, din, cs_b;
   logic [5:0]  cfg = 6'h00;  // type, width, count lo/hi, capacity lo/hi
   logic [10:0] pins, row, col;
   logic [7:0]  cas_b;
   logic [4:0]  shifts;
   int n_mismatch = 0, checks_done = 0;
   always #2.5 mclk = ~mclk;
   initial #3 forever #16 lclk = ~lclk;  // Phase unrelated to mclk
   rxm_ext_mem_port u_rxm_ext_mem_port (.mclk_in(mclk), .rst_b_in(rst_b), .link_clk_in(lclk),
      .req_valid_in(vld), .req_write_in(wr), .req_rom_in(rom), .req_addr_in(addr), .req_wdata_in(wd),
      .req_ready_out(ready), .rsp_valid_out(rsp), .rsp_rdata_out(rd), .rsp_err_out(err),
      .memory_type_select_in(cfg[0]), .dram_width_select_in(cfg[1]), .memory_count_sel_lo_in(cfg[2]),
      .memory_count_sel_hi_in(cfg[3]), .memory_capacity_sel_lo_in(cfg[4]), .memory_capacity_sel_hi_in(cfg[5]),
      .mem_addr_out(pins), .write_enable_b_out(we_b), .memory_data_line_out(dout),
      .memory_data_line_oe_out(oe), .memory_data_line_in(din), .voice_rom_data_in(rom_d),
      .row_strobe_b_out(ras_b), .col_strobe_b_out(cas_b), .memory_chip_selects_b_out(cs_b));
   rxm_mem_model u_rxm_mem_model (.link_clk_in(lclk), .addr_in(pins), .we_b_in(we_b), .dout_in(dout),
      .oe_in(oe), .ras_b_in(ras_b), .cas_b_in(cas_b), .cs_b_in(cs_b), .din_out(din), .rom_out(rom_d),
      .shifts_out(shifts), .row_out(row), .col_out(col));
   // ==========================================================
   // Shared compare, request and mode tasks
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic access(input logic w, input logic r, input logic [24:0] a, input logic [3:0] d);
      int i;
      @(posedge mclk);
      #1 vld = 1'h1; wr = w; rom = r; addr = a; wd = d;
      @(posedge mclk);
      #1 vld = 1'h0;
      for (i = 0; i < 2000; i++) begin  // Bounded wait for the answer pulse
         @(posedge mclk);
         #1 if (rsp === 1'h1) break;
      end
      if (i == 2000) n_mismatch++;
   endtask : access
   task automatic mode(input logic [5:0] c);
      @(posedge mclk);
      #1 cfg = c;
      repeat (40) @(posedge mclk);  // Let the pin synchronisers settle
   endtask : mode
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      check({ready, we_b, ras_b, rsp}, 12'h00e);
      check({cas_b, cs_b}, 12'hfff);
      check({oe, pins[4:0]}, 12'h000);
   endtask : t_reset
   task automatic t_serial;
      mode(6'h10);  // Serial register, capacity index up to 1
      access(1'h1, 1'h0, 25'h0400000, 4'h1);
      check({err, 6'h00, shifts}, 12'h00c);
      access(1'h0, 1'h0, 25'h0400000, 4'h0);
      check(rd[0], 12'h001);
      access(1'h1, 1'h0, 25'h0400000, 4'h0);
      access(1'h0, 1'h0, 25'h0400000, 4'h0);
      check(rd[0], 12'h000);
      access(1'h0, 1'h1, 25'h0000000, 4'h0);
      check({err, rd[0]}, 12'h001);
      access(1'h0, 1'h0, 25'h0800000, 4'h0);
      check(err, 12'h001);
      mode(6'h14);  // Larger devices move the chip index up one bit
      access(1'h0, 1'h0, 25'h0800000, 4'h0);
      check({err, rd[0]}, 12'h000);
   endtask : t_serial
   task automatic t_dram;
      mode(6'h03);  // DRAM, four-bit wide, one device
      access(1'h1, 1'h0, 25'h0152b5a, 4'ha);
      check({1'h0, row}, 12'h2a5);
      check({1'h0, col}, 12'h35a);
      access(1'h0, 1'h0, 25'h0152b5a, 4'h0);
      check({err, rd}, 12'h00a);
      mode(6'h01);  // One-bit wide
      access(1'h1, 1'h0, 25'h0000010, 4'h1);
      access(1'h0, 1'h0, 25'h0000010, 4'h0);
      check(rd[0], 12'h001);
      access(1'h0, 1'h1, 25'h0000000, 4'h0);
      check(err, 12'h001);
      access(1'h0, 1'h0, 25'h0400000, 4'h0);
      check({err, cs_b}, 12'h01f);
   endtask : t_dram
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   // Main sequence and watchdog
   initial begin
      repeat (4) @(posedge lclk);
      #1 rst_b = 1'h1;
      t_reset();
      t_serial();
      t_dram();
      complete_run();
   end
   initial begin
      #100us n_mismatch++;
      complete_run();
   end
endmodule : rxm_ext_mem_port_bench

`default_nettype wire

// ### verification/rxm_mem_model.sv
// Purpose : Far-side serial register, voice ROM and DRAM for the memory port
// Assumes : One data word is held; addresses are captured, not decoded
// Notes   : A released data lane shows the inverse of the held word
`default_nettype none

module rxm_mem_model #(
   parameter logic ROM_BIT = 1'h1
) (
   input  wire logic        link_clk_in,
   input  wire logic [10:0] addr_in,
   input  wire logic        we_b_in,
   input  wire logic [3:0]  dout_in,
   input  wire logic [3:0]  oe_in,
   input  wire logic        ras_b_in,
   input  wire logic [7:0]  cas_b_in,
   input  wire logic [3:0]  cs_b_in,
   output logic      [3:0]  din_out,
   output logic             rom_out,
   output logic      [4:0]  shifts_out,
   output logic      [10:0] row_out,
   output logic      [10:0] col_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] mem = 4'h0;
   logic       drv = 1'h0;
   logic [4:0] cnt = 5'h00;
   logic       cas_idle;
   assign cas_idle = &cas_b_in;  // Plain signal as edge source, not an expression
   // ==========================================================
   // Serial address: count clocks until the load strobe
   always @(posedge addr_in[3]) if (cs_b_in != 4'hf) cnt <= cnt + 5'h01;
   always @(posedge addr_in[2]) if (cs_b_in != 4'hf) begin
      shifts_out <= cnt;
      cnt <= 5'h00;
   end
   // DRAM row latch on the row strobe
   always @(negedge ras_b_in) row_out <= addr_in;
   // Data clock or column strobe moves data; gated so DRAM address bits never clock
   always @(posedge addr_in[4] or negedge cas_idle) begin
      if (!(&cas_b_in)) col_out <= addr_in;
      if (cs_b_in != 4'hf || !(&cas_b_in)) begin
         if (!we_b_in) mem <= (dout_in & oe_in) | (mem & ~oe_in);
         else drv <= 1'h1;
      end
   end
   // Released once all selects and column strobes are inactive
   always @(posedge link_clk_in) if (cs_b_in == 4'hf && (&cas_b_in)) drv <= 1'h0;
   assign din_out = (oe_in & dout_in) | (~oe_in & (drv ? mem : ~mem));
   assign rom_out = (cs_b_in != 4'hf) ? ROM_BIT : ~ROM_BIT;
endmodule : rxm_mem_model

`default_nettype wire
